// ---- csd_core.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Separate program and data buses; next word fetched while current executes.
// - Thirty-two byte registers; read, compute and write back in one clock.
// - Three register pairs act as 16-bit data pointers; one also reads flash.
// - ALU works register-register, register-immediate and single-register in one cycle.
// - Decoder takes one-word and two-word instructions.
// - Every ALU operation except swap updates the status flags from its result.
// - Interrupt entry and return never save or restore the status register.
// - Status bit 7 gates all interrupts; when set, the sources decide.
// - Taking an interrupt clears the gate; interrupt return sets it again.
// - Dedicated instructions set and clear the interrupt gate.
// - Status bit 6 stores one bit copied from or into a register.
// - Status bit 5 holds the carry out of the low nibble.
// - Each source has its own vector; lowest vector wins when several pend.
// - Interrupt entry and calls push the return address onto the data stack.
// - The 64 I/O locations are reached by I/O instructions and at 0x20-0x5F.
// - Locations 0x60-0xFF are reached only through data load and store forms.
// - Flash self-write of application only from boot code; lock bits protect sections.
// - Sign bit always equals negative xor overflow.
// - Push and pop move the stack by one; call, interrupt, return by two.
module csd_core
  import csd_pkg::*;
#(
  parameter int          IRQ_COUNT    = 8,
  parameter int          VECTOR_WORDS = 1,
  parameter logic [15:0] BOOT_START   = 16'h0C00,
  parameter logic [15:0] STACK_TOP    = 16'h04FF
)(
  input  wire logic                 I_CLK,
  input  wire logic                 I_RESET_N,
  output logic [15:0]               O_PROG_ADDR,
  input  wire logic [15:0]          I_PROG_DATA,
  output logic [15:0]               O_DATA_ADDR,
  output logic [7:0]                O_DATA_WDATA,
  output logic                      O_DATA_WE,
  output logic                      O_DATA_RE,
  input  wire logic [7:0]           I_DATA_RDATA,
  input  wire logic [IRQ_COUNT-1:0] I_IRQ,
  output logic [IRQ_COUNT-1:0]      O_IRQ_ACK,
  input  wire logic                 I_APP_LOCK,
  input  wire logic                 I_BOOT_LOCK,
  output logic [15:0]               O_SPM_ADDR,
  output logic [15:0]               O_SPM_DATA,
  output logic                      O_SPM_WE,
  output logic [7:0]                O_STATUS,
  output logic [15:0]               O_STACK_PTR
);

  localparam int IDX_W = (IRQ_COUNT > 1) ? $clog2(IRQ_COUNT) : 1;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [15:0]               pc;
    logic [15:0]               ir;
    logic                      ir_valid;
    logic [15:0]               sp;
    logic [7:0]                sreg;
    logic [7:0]                hold;
    logic                      return_from_irq_op;
    csd_phase_e                phase;
    logic [15:0]               spm_addr;
    logic [15:0]               spm_data;
    logic                      spm_we;
  } csd_state_s;

  csd_state_s s;
  csd_state_s n;

  logic [4:0]     d5;
  logic [4:0]     r5;
  logic [4:0]     d4;
  logic [7:0]     rd_v;
  logic [7:0]     rr_v;
  logic [7:0]     rh_v;
  logic [7:0]     k8;
  logic [15:0]    ptr_y;
  logic [15:0]    ptr_z;
  logic [15:0]    here;
  csd_alu_e       alu_op;
  logic [7:0]     alu_a;
  logic [7:0]     alu_b;
  logic [7:0]     alu_res;
  logic [7:0]     alu_flags;
  logic           alu_use;
  logic           alu_wb;
  logic [4:0]     alu_dst;
  logic [15:0]    prog_addr;
  logic [15:0]    daddr;
  logic [7:0]     dwdata;
  logic           dwe;
  logic           dre;
  logic           int_hit;
  logic           mem_en;
  logic           mem_st;
  logic [15:0]    maddr;
  logic           ptr_wr;
  logic [4:0]     ptr_lo;
  logic [15:0]    ptr_old;
  logic [15:0]    ptr_new;
  logic           jump_en;
  logic [15:0]    tgt;
  logic           call_en;
  logic [15:0]    ret_addr;
  logic           irq_take;
  logic [IDX_W-1:0] irq_idx;
  logic [IRQ_COUNT-1:0] irq_ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Data space read: registers and core registers answer here, the rest comes from the bus.
  function automatic logic [7:0] read_space(input logic [15:0] a, input csd_state_s st,
                                            input logic [7:0] ext);
    logic [7:0] v;
    v = ext;
    if (a < IO_FIRST) begin
      v = st.regs[a[4:0]];
    end else if (a == io_addr(IO_STATUS_OFS)) begin
      v = st.sreg;
    end else if (a == io_addr(IO_SP_LO_OFS)) begin
      v = st.sp[7:0];
    end else if (a == io_addr(IO_SP_HI_OFS)) begin
      v = st.sp[15:8];
    end
    return v;
  endfunction : read_space

  ////////////////////////////////////////////////////////////////////////////////
  // Operand fields of the word under execution.
  assign d5    = s.ir[8:4];
  assign r5    = {s.ir[9], s.ir[3:0]};
  assign d4    = {1'b1, s.ir[7:4]};
  assign rd_v  = s.regs[d5];
  assign rr_v  = s.regs[r5];
  assign rh_v  = s.regs[d4];
  assign k8    = {s.ir[11:8], s.ir[3:0]};
  assign ptr_y = {s.regs[PTR_Y_LO + 5'h01], s.regs[PTR_Y_LO]};
  assign ptr_z = {s.regs[PTR_Z_LO + 5'h01], s.regs[PTR_Z_LO]};
  assign here  = s.pc - 16'h0001;

  // ALU operand and operation select, kept apart so no path loops through the ALU.
  always_comb begin
    alu_op = ALU_PASS;
    alu_a  = rd_v;
    alu_b  = rr_v;
    casez (s.ir[15:10])
      6'b000001: alu_op = ALU_SBC;
      6'b000010: alu_op = ALU_SBC;
      6'b000011: alu_op = ALU_ADD;
      6'b000101: alu_op = ALU_SUB;
      6'b000110: alu_op = ALU_SUB;
      6'b000111: alu_op = ALU_ADC;
      6'b001000: alu_op = ALU_AND;
      6'b001001: alu_op = ALU_EOR;
      6'b001010: alu_op = ALU_OR;
      6'b0011??, 6'b01????: begin
        alu_a  = rh_v;
        alu_b  = k8;
        alu_op = (s.ir[15:12] == 4'h4) ? ALU_SBC :
                 (s.ir[15:12] == 4'h6) ? ALU_OR  :
                 (s.ir[15:12] == 4'h7) ? ALU_AND : ALU_SUB;
      end
      6'b100101: begin
        if (!s.ir[9]) begin
          case (s.ir[3:0])
            4'h0:    alu_op = ALU_COM;
            4'h1:    alu_op = ALU_NEG;
            4'h2:    alu_op = ALU_SWAP;
            4'h3:    alu_op = ALU_INC;
            4'h5:    alu_op = ALU_ASR;
            4'h6:    alu_op = ALU_LSR;
            4'h7:    alu_op = ALU_ROR;
            4'hA:    alu_op = ALU_DEC;
            default: alu_op = ALU_PASS;
          endcase
        end
      end
      default: alu_op = ALU_PASS;
    endcase
  end

  csd_alu u_alu (
    .i_op    (alu_op),
    .i_a     (alu_a),
    .i_b     (alu_b),
    .i_flags (s.sreg),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the whole core.
  always_comb begin
    n         = s;
    prog_addr = s.pc;
    daddr     = 16'h0000;
    dwdata    = 8'h00;
    dwe       = 1'b0;
    dre       = 1'b0;
    mem_en    = 1'b0;
    mem_st    = 1'b0;
    maddr     = 16'h0000;
    ptr_wr    = 1'b0;
    ptr_lo    = PTR_Z_LO;
    ptr_old   = 16'h0000;
    ptr_new   = 16'h0000;
    alu_use   = 1'b0;
    alu_wb    = 1'b0;
    alu_dst   = d5;
    jump_en   = 1'b0;
    tgt       = 16'h0000;
    call_en   = 1'b0;
    ret_addr  = s.pc;
    irq_ack   = '0;
    n.spm_we  = 1'b0;
    // The next word is fetched while the current one executes.
    n.ir       = I_PROG_DATA;
    n.ir_valid = 1'b1;
    n.pc       = s.pc + 16'h0001;
    // Lowest index pending wins.
    irq_idx = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (I_IRQ[i]) begin
        irq_idx = IDX_W'(i);
      end
    end
    // Only a real fetched word can be preempted, so the return address is always exact.
    irq_take = s.sreg[SR_I] & (|I_IRQ) & s.ir_valid & (s.phase == PH_EXEC);
    unique case (s.phase)
      PH_PUSH_HI: begin
        daddr  = s.sp;
        dwdata = s.hold;
        dwe    = 1'b1;
        n.sp   = s.sp - STACK_STEP;
        n.phase = PH_EXEC;
      end
      PH_POP_LO: begin
        daddr      = s.sp + STACK_STEP;
        dre        = 1'b1;
        n.sp       = s.sp + STACK_STEP;
        n.pc       = {s.hold, read_space(daddr, s, I_DATA_RDATA)};
        n.ir       = NOP_WORD;
        n.ir_valid = 1'b0;
        n.phase    = PH_EXEC;
        if (s.return_from_irq_op) begin
          n.sreg[SR_I] = 1'b1;
        end
      end
      PH_LPM: begin
        prog_addr  = {1'b0, ptr_z[15:1]};
        n.regs[0]  = ptr_z[0] ? I_PROG_DATA[15:8] : I_PROG_DATA[7:0];
        n.ir       = NOP_WORD;
        n.ir_valid = 1'b0;
        n.pc       = s.pc;
        n.phase    = PH_EXEC;
      end
      PH_EXEC: begin
        if (irq_take) begin
          irq_ack[irq_idx] = 1'b1;
          n.sreg[SR_I]     = 1'b0;
          tgt      = 16'((int'(irq_idx) + 1) * VECTOR_WORDS);
          jump_en  = 1'b1;
          call_en  = 1'b1;
          ret_addr = here;
        end else begin
          casez (s.ir)
            16'b0000_0000_0000_0000: ;
            16'b0000_01??_????_????, 16'b0001_01??_????_????,
            16'b0011_????_????_????: begin
              alu_use = 1'b1;
            end
            16'b0000_1???_????_????, 16'b0001_1???_????_????,
            16'b0010_0???_????_????, 16'b0010_10??_????_????: begin
              alu_use = 1'b1;
              alu_wb  = 1'b1;
            end
            16'b0010_11??_????_????: n.regs[d5] = rr_v;
            16'b01??_????_????_????: begin
              alu_use = 1'b1;
              alu_wb  = 1'b1;
              alu_dst = d4;
            end
            16'b10?0_????_????_????: begin
              mem_en = 1'b1;
              mem_st = s.ir[9];
              maddr  = (s.ir[3] ? ptr_y : ptr_z) +
                       {10'h000, s.ir[13], s.ir[11:10], s.ir[2:0]};
            end
            16'b1001_00??_????_????: begin
              mem_st = s.ir[9];
              case (s.ir[3:0])
                4'h0: begin
                  mem_en     = 1'b1;
                  maddr      = I_PROG_DATA;
                  n.ir       = NOP_WORD;
                  n.ir_valid = 1'b0;
                end
                4'h1, 4'h2, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE: begin
                  ptr_lo  = (s.ir[3:2] == 2'b11) ? PTR_X_LO :
                            (s.ir[3] ? PTR_Y_LO : PTR_Z_LO);
                  ptr_old = {s.regs[ptr_lo + 5'h01], s.regs[ptr_lo]};
                  mem_en  = 1'b1;
                  maddr   = s.ir[1] ? ptr_old - 16'h0001 : ptr_old;
                  ptr_new = s.ir[1] ? ptr_old - 16'h0001 : ptr_old + 16'h0001;
                  ptr_wr  = s.ir[1] | s.ir[0];
                end
                4'hF: begin
                  mem_en = 1'b1;
                  maddr  = s.ir[9] ? s.sp : s.sp + STACK_STEP;
                  n.sp   = s.ir[9] ? s.sp - STACK_STEP : s.sp + STACK_STEP;
                end
                default: ;
              endcase
            end
            16'b1001_010?_????_????: begin
              case (s.ir[3:0])
                4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA: begin
                  alu_use = 1'b1;
                  alu_wb  = 1'b1;
                end
                4'h8: begin
                  if (!s.ir[8]) begin
                    n.sreg[s.ir[6:4]] = ~s.ir[7];
                  end else if (s.ir[7:4] == 4'h0 || s.ir[7:4] == 4'h1) begin
                    daddr      = s.sp + STACK_STEP;
                    dre        = 1'b1;
                    n.hold     = read_space(daddr, s, I_DATA_RDATA);
                    n.sp       = s.sp + STACK_STEP;
                    n.return_from_irq_op     = s.ir[4];
                    n.phase    = PH_POP_LO;
                    n.ir       = NOP_WORD;
                    n.ir_valid = 1'b0;
                    n.pc       = s.pc;
                  end else if (s.ir[7:4] == 4'hC) begin
                    n.phase    = PH_LPM;
                    n.ir       = NOP_WORD;
                    n.ir_valid = 1'b0;
                    n.pc       = s.pc;
                  end else if (s.ir[7:4] == 4'hE) begin
                    n.spm_addr = ptr_z;
                    n.spm_data = {s.regs[1], s.regs[0]};
                    n.spm_we   = (here >= BOOT_START) &
                                 (({1'b0, ptr_z[15:1]} < BOOT_START) ? ~I_APP_LOCK
                                                                     : ~I_BOOT_LOCK);
                  end
                end
                4'hC, 4'hD, 4'hE, 4'hF: begin
                  tgt      = I_PROG_DATA;
                  jump_en  = 1'b1;
                  call_en  = s.ir[1];
                  ret_addr = s.pc + 16'h0001;
                end
                default: ;
              endcase
            end
            16'b1011_????_????_????: begin
              mem_en = 1'b1;
              mem_st = s.ir[11];
              maddr  = io_addr({s.ir[10:9], s.ir[3:0]});
            end
            16'b110?_????_????_????: begin
              tgt     = s.pc + {{4{s.ir[11]}}, s.ir[11:0]};
              jump_en = 1'b1;
              call_en = s.ir[12];
            end
            16'b1110_????_????_????: n.regs[d4] = k8;
            16'b1111_0???_????_????: begin
              tgt     = s.pc + {{9{s.ir[9]}}, s.ir[9:3]};
              jump_en = (s.sreg[s.ir[2:0]] != s.ir[10]);
            end
            16'b1111_100?_????_0???: n.regs[d5][s.ir[2:0]] = s.sreg[SR_T];
            16'b1111_101?_????_0???: n.sreg[SR_T] = rd_v[s.ir[2:0]];
            default: ;
          endcase
        end
      end
    endcase
    // Loads and stores; register file, I/O and extended I/O share one data space.
    if (mem_en) begin
      daddr = maddr;
      if (mem_st) begin
        dwe    = 1'b1;
        dwdata = rd_v;
      end else begin
        dre        = 1'b1;
        n.regs[d5] = read_space(maddr, s, I_DATA_RDATA);
      end
    end
    if (ptr_wr) begin
      n.regs[ptr_lo]         = ptr_new[7:0];
      n.regs[ptr_lo + 5'h01] = ptr_new[15:8];
    end
    // Flags come from every ALU result except swap; untouched flags keep their value.
    if (alu_use) begin
      n.sreg = alu_flags;
      if (alu_wb) begin
        n.regs[alu_dst] = alu_res;
      end
    end
    if (jump_en) begin
      n.pc       = tgt;
      n.ir       = NOP_WORD;
      n.ir_valid = 1'b0;
    end
    // Only the return address goes on the stack; status is left to software.
    if (call_en) begin
      daddr   = s.sp;
      dwdata  = ret_addr[7:0];
      dwe     = 1'b1;
      n.sp    = s.sp - STACK_STEP;
      n.hold  = ret_addr[15:8];
      n.phase = PH_PUSH_HI;
    end
    // Internal locations of the data space take writes here and stay off the bus.
    int_hit = (daddr < IO_FIRST) || (daddr == io_addr(IO_STATUS_OFS)) ||
              (daddr == io_addr(IO_SP_LO_OFS)) || (daddr == io_addr(IO_SP_HI_OFS));
    if (dwe) begin
      if (daddr < IO_FIRST) begin
        n.regs[daddr[4:0]] = dwdata;
      end else if (daddr == io_addr(IO_STATUS_OFS)) begin
        n.sreg = dwdata;
      end else if (daddr == io_addr(IO_SP_LO_OFS)) begin
        n.sp[7:0] = dwdata;
      end else if (daddr == io_addr(IO_SP_HI_OFS)) begin
        n.sp[15:8] = dwdata;
      end
    end
    // Sign is derived, never stored on its own, so it cannot drift from N and V.
    n.sreg[SR_S] = n.sreg[SR_N] ^ n.sreg[SR_V];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      s       <= '0;
      s.pc    <= PC_RESET;
      s.ir    <= NOP_WORD;
      s.sreg  <= STATUS_RESET;
      s.sp    <= STACK_TOP;
      s.phase <= PH_EXEC;
    end else begin
      s <= n;
    end
  end

  // Bus strobes are combinational so a single-cycle memory answers in the same clock.
  assign O_PROG_ADDR  = prog_addr;
  assign O_DATA_ADDR  = daddr;
  assign O_DATA_WDATA = dwdata;
  assign O_DATA_WE    = dwe & ~int_hit;
  assign O_DATA_RE    = dre & ~int_hit;
  assign O_IRQ_ACK    = irq_ack;
  assign O_SPM_ADDR   = s.spm_addr;
  assign O_SPM_DATA   = s.spm_data;
  assign O_SPM_WE     = s.spm_we;
  assign O_STATUS     = s.sreg;
  assign O_STACK_PTR  = s.sp;

endmodule : csd_core

// ---- csd_pkg.sv ----
package csd_pkg;

  // Core sizes and values after reset.
  localparam int          REG_COUNT    = 32;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] NOP_WORD     = 16'h0000;
  localparam logic [15:0] STACK_STEP   = 16'h0001;

  // Status bit positions.
  localparam int SR_I = 7;
  localparam int SR_T = 6;
  localparam int SR_H = 5;
  localparam int SR_S = 4;
  localparam int SR_V = 3;
  localparam int SR_N = 2;
  localparam int SR_Z = 1;
  localparam int SR_C = 0;

  // Data space windows.
  localparam logic [15:0] IO_FIRST     = 16'h0020;
  localparam logic [15:0] IO_LAST      = 16'h005F;
  localparam logic [15:0] EXT_IO_FIRST = 16'h0060;
  localparam logic [15:0] EXT_IO_LAST  = 16'h00FF;

  // Core registers inside the I/O window.
  localparam logic [5:0] IO_SP_LO_OFS  = 6'h3D;
  localparam logic [5:0] IO_SP_HI_OFS  = 6'h3E;
  localparam logic [5:0] IO_STATUS_OFS = 6'h3F;

  // Low halves of the three pointer pairs.
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR,
    ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ROR, ALU_ASR, ALU_SWAP
  } csd_alu_e;

  typedef enum logic [1:0] {PH_EXEC, PH_PUSH_HI, PH_POP_LO, PH_LPM} csd_phase_e;

  // Data space address of an I/O location.
  function automatic logic [15:0] io_addr(input logic [5:0] ofs);
    return IO_FIRST + {10'h000, ofs};
  endfunction : io_addr

endpackage : csd_pkg

// ---- csd_alu.sv ----
`timescale 1ns/1ps
module csd_alu
  import csd_pkg::*;
(
  input  wire csd_alu_e   i_op,
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic [7:0] i_flags,
  output logic      [7:0] o_res,
  output logic      [7:0] o_flags
);

  logic [8:0] wide;
  logic [7:0] x;
  logic [7:0] y;
  logic       cin;

  // One pass of pure logic, so every operation settles in a single cycle.
  always_comb begin
    x       = (i_op == ALU_NEG) ? 8'h00 : i_a;
    y       = (i_op == ALU_NEG) ? i_a : i_b;
    cin     = ((i_op == ALU_ADC) || (i_op == ALU_SBC)) ? i_flags[SR_C] : 1'b0;
    wide    = 9'h000;
    o_res   = i_a;
    o_flags = i_flags;
    unique case (i_op)
      ALU_PASS: o_res = i_a;
      ALU_SWAP: o_res = {i_a[3:0], i_a[7:4]};
      ALU_ADD, ALU_ADC: begin
        wide           = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        o_res          = wide[7:0];
        o_flags[SR_C]  = wide[8];
        o_flags[SR_H]  = (x[3] & y[3]) | (y[3] & ~wide[3]) | (~wide[3] & x[3]);
        o_flags[SR_V]  = (x[7] & y[7] & ~wide[7]) | (~x[7] & ~y[7] & wide[7]);
      end
      ALU_SUB, ALU_SBC, ALU_NEG: begin
        wide           = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        o_res          = wide[7:0];
        o_flags[SR_C]  = wide[8];
        o_flags[SR_H]  = (~x[3] & y[3]) | (y[3] & wide[3]) | (wide[3] & ~x[3]);
        o_flags[SR_V]  = (x[7] & ~y[7] & ~wide[7]) | (~x[7] & y[7] & wide[7]);
      end
      ALU_AND, ALU_OR, ALU_EOR, ALU_COM: begin
        o_res         = (i_op == ALU_AND) ? (i_a & i_b) :
                        (i_op == ALU_OR)  ? (i_a | i_b) :
                        (i_op == ALU_EOR) ? (i_a ^ i_b) : ~i_a;
        o_flags[SR_V] = 1'b0;
        if (i_op == ALU_COM) begin
          o_flags[SR_C] = 1'b1;
        end
      end
      ALU_INC: begin
        o_res         = i_a + 8'h01;
        o_flags[SR_V] = (o_res == 8'h80);
      end
      ALU_DEC: begin
        o_res         = i_a - 8'h01;
        o_flags[SR_V] = (o_res == 8'h7F);
      end
      ALU_LSR, ALU_ROR, ALU_ASR: begin
        o_res         = {(i_op == ALU_ROR) ? i_flags[SR_C] :
                         (i_op == ALU_ASR) ? i_a[7] : 1'b0, i_a[7:1]};
        o_flags[SR_C] = i_a[0];
        o_flags[SR_V] = o_res[7] ^ i_a[0];
      end
    endcase
    // Result flags; the chained zero of subtract with carry keeps multi-byte compares honest.
    if ((i_op != ALU_PASS) && (i_op != ALU_SWAP)) begin
      o_flags[SR_N] = o_res[7];
      o_flags[SR_Z] = (o_res == 8'h00) & ((i_op == ALU_SBC) ? i_flags[SR_Z] : 1'b1);
      o_flags[SR_S] = o_flags[SR_N] ^ o_flags[SR_V];
    end
  end

endmodule : csd_alu

// ---- csd_core_properties.sv ----
`timescale 1ns/1ps
// Port-level checks on interrupt gating, priority, stacking and flags.
module csd_core_properties
  import csd_pkg::*;
#(
  parameter int          IRQ_COUNT  = 8,
  parameter logic [15:0] BOOT_START = 16'h0C00
)(
  input wire logic                 I_CLK,
  input wire logic                 I_RESET_N,
  input wire logic [IRQ_COUNT-1:0] I_IRQ,
  input wire logic [IRQ_COUNT-1:0] O_IRQ_ACK,
  input wire logic [15:0]          O_PROG_ADDR,
  input wire logic [15:0]          O_DATA_ADDR,
  input wire logic                 O_DATA_WE,
  input wire logic                 O_SPM_WE,
  input wire logic [7:0]           O_STATUS,
  input wire logic [15:0]          O_STACK_PTR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Entry stacks two bytes downwards; pointer ends two lower.
  sequence s_push_lo; O_DATA_WE && O_DATA_ADDR == O_STACK_PTR; endsequence
  sequence s_push_hi; O_DATA_WE && O_DATA_ADDR == $past(O_STACK_PTR) - 16'h0001; endsequence
  a_gate_blocks: assert property (!O_STATUS[SR_I] |-> O_IRQ_ACK == '0)
    else $error("ack while gate clear");
  a_take_clears: assert property (|O_IRQ_ACK |=> !O_STATUS[SR_I])
    else $error("gate kept after take");
  a_ack_onehot: assert property (|O_IRQ_ACK |-> $onehot(O_IRQ_ACK & I_IRQ))
    else $error("ack not one pending source");
  a_ack_lowest: assert property (|O_IRQ_ACK |-> ((O_IRQ_ACK - 1'b1) & I_IRQ) == '0)
    else $error("lower source skipped");
  a_entry_push: assert property (|O_IRQ_ACK |-> s_push_lo ##1 s_push_hi
    ##1 O_STACK_PTR == $past(O_STACK_PTR, 2) - 16'h0002)
    else $error("entry stacking wrong");
  a_sign_xor: assert property (O_STATUS[SR_S] == (O_STATUS[SR_N] ^ O_STATUS[SR_V]))
    else $error("sign not n xor v");
  a_reg_hidden: assert property (O_DATA_WE |-> O_DATA_ADDR >= IO_FIRST)
    else $error("register file on data bus");
  a_spm_boot: assert property (O_SPM_WE |-> $past(O_PROG_ADDR, 2) >= BOOT_START)
    else $error("self write outside boot");
endmodule : csd_core_properties

bind csd_core csd_core_properties #(.IRQ_COUNT(IRQ_COUNT), .BOOT_START(BOOT_START)) u_props (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_IRQ(I_IRQ), .O_IRQ_ACK(O_IRQ_ACK),
  .O_PROG_ADDR(O_PROG_ADDR), .O_DATA_ADDR(O_DATA_ADDR), .O_DATA_WE(O_DATA_WE),
  .O_SPM_WE(O_SPM_WE), .O_STATUS(O_STATUS), .O_STACK_PTR(O_STACK_PTR));

// ---- csd_mem_model.sv ----
`timescale 1ns/1ps
// Program flash and data memory behind the core; both read asynchronously.
module csd_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_prog_addr,
  output logic      [15:0] o_prog_data,
  input  wire logic [15:0] i_data_addr,
  input  wire logic [7:0]  i_data_wdata,
  input  wire logic        i_data_we,
  input  wire logic        i_data_re,
  output logic      [7:0]  o_data_rdata
);
  logic [15:0] prog [0:255];
  logic [7:0]  data [0:16'h04FF];
  logic [7:0]  last;
  // Undriven read data shows the inverse of the last byte, so stale values never match.
  always_comb begin
    o_prog_data = prog[i_prog_addr[7:0]];
    o_data_rdata = i_data_re ? data[i_data_addr] : ~last;
  end
  // Stores land at the edge ending the strobed cycle.
  always @(posedge i_clk) begin
    if (i_data_we && i_data_addr <= 16'h04FF) data[i_data_addr] <= i_data_wdata;
    if (i_data_re) last <= data[i_data_addr];
  end
endmodule : csd_mem_model

// ---- csd_core_tb_top.sv ----
`timescale 1ns/1ps
module csd_core_tb_top;
  import csd_pkg::*;
  logic I_CLK = 0, I_RESET_N = 0;
  logic [7:0]  I_IRQ = 8'h24, ack_q = 8'h00;
  logic [15:0] pa, pd, da, sa, sd, sp;
  logic [7:0]  wd, rd, ack, st;
  logic        we, re, swe;
  int          n_mismatch = 0, samples_checked = 0, n_ack = 0, n_spm = 0;
  csd_core uut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .O_PROG_ADDR(pa), .I_PROG_DATA(pd),
    .O_DATA_ADDR(da), .O_DATA_WDATA(wd), .O_DATA_WE(we), .O_DATA_RE(re), .I_DATA_RDATA(rd),
    .I_IRQ(I_IRQ), .O_IRQ_ACK(ack), .I_APP_LOCK(1'b0), .I_BOOT_LOCK(1'b0), .O_SPM_ADDR(sa),
    .O_SPM_DATA(sd), .O_SPM_WE(swe), .O_STATUS(st), .O_STACK_PTR(sp));
  csd_mem_model mem (.i_clk(I_CLK), .i_prog_addr(pa), .o_prog_data(pd), .i_data_addr(da),
    .i_data_wdata(wd), .i_data_we(we), .i_data_re(re), .o_data_rdata(rd));
  initial begin
    forever #5 I_CLK = ~I_CLK;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Sources stay pending until the falling edge one cycle after their acknowledge; order is checked.
  always @(negedge I_CLK) begin
    I_IRQ <= I_IRQ & ~ack_q;
    ack_q <= ack;
    if (swe === 1'b1) n_spm++;
    if (|ack) begin
      check("ack", (n_ack == 0) ? 16'h0004 : 16'h0020, {8'h00, ack});
      check("status at take", 16'h00E0, {8'h00, st});
      n_ack++;
    end
  end
  // Vectors return at once; main code works flags, stores, then opens and closes the gate.
  // A self-write placed in application code must never reach the flash write strobe.
  task automatic load_program();
    foreach (mem.prog[i]) mem.prog[i] = NOP_WORD;
    for (int v = 1; v <= 8; v++) mem.prog[v] = 16'h9518;
    mem.prog[0] = 16'hC00F;
    mem.prog[16:27] = '{16'hE00F, 16'hE011, 16'h0F01, 16'hFB04, 16'hB900, 16'h9300,
      16'h0060, 16'h9478, 16'h0000, 16'h95E8, 16'h94F8, 16'hCFFF};
  endtask : load_program
  task automatic scen_reset();
    repeat (12) @(negedge I_CLK);
    I_RESET_N = 1;
    @(negedge I_CLK);
    check("status reset", {8'h00, STATUS_RESET}, {8'h00, st});
    check("stack reset", 16'h04FF, sp);
  endtask : scen_reset
  task automatic scen_run();
    int k;
    for (k = 0; k < 2000 && !(n_ack == 2 && pa == 16'h001B); k++) @(negedge I_CLK);
    if (k == 2000) check("run ends", 16'h0001, 16'h0000);
    repeat (4) @(negedge I_CLK);
    check("final status", 16'h0060, {8'h00, st});
    check("stack back", 16'h04FF, sp);
    check("io store", 16'h0010, {8'h00, mem.data[16'h0020]});
    check("ext store", 16'h0010, {8'h00, mem.data[16'h0060]});
    check("acks", 16'h0002, 16'(n_ack));
    check("spm outside boot", 16'h0000, 16'(n_spm));
  endtask : scen_run
  initial begin
    load_program();
    scen_reset();
    scen_run();
    test_done();
  end
endmodule : csd_core_tb_top
